// ### eiu_pkg.sv
// Package with register addresses, field positions and vectors of the unit.
package eiu_pkg;

  // Special function register addresses.
  localparam logic [7:0] FLAGS_ADDR    = 8'h91;
  localparam logic [7:0] WAKE_ADDR     = 8'hD8;
  localparam logic [7:0] ENABLE_ADDR   = 8'hE8;
  localparam logic [7:0] PRIO_ADDR     = 8'hF8;
  localparam logic [7:0] STD_EN_ADDR   = 8'hA8;
  localparam logic [7:0] STD_PRIO_ADDR = 8'hB8;

  // Source index, equal to the bit in the enable and priority registers.
  localparam int SRC_ADC  = 0;
  localparam int SRC_SPI  = 1;
  localparam int SRC_DR   = 2;
  localparam int SRC_AM   = 3;
  localparam int SRC_WAKE = 4;
  localparam int NUM_SRC  = 5;

  // Flag positions in the flag registers, and the global enable bit.
  localparam int FLAG_ADC_BIT  = 4;
  localparam int FLAG_SPI_BIT  = 5;
  localparam int FLAG_DR_BIT   = 6;
  localparam int FLAG_AM_BIT   = 7;
  localparam int WAKE_FLAG_BIT = 3;
  localparam int GLOBAL_EN_BIT = 7;

  // Fixed read values of the reserved bits.
  localparam logic [7:0] FLAGS_FIXED  = 8'h08;
  localparam logic [7:0] WAKE_FIXED   = 8'h40;
  localparam logic [7:0] EN_FIXED     = 8'hE0;

  // Reset values.
  localparam logic [4:0] EN_RESET     = 5'h00;
  localparam logic [4:0] PRIO_RESET   = 5'h00;

  // Service routine addresses indexed by source.
  localparam logic [15:0] VEC_ADC  = 16'h0043;
  localparam logic [15:0] VEC_SPI  = 16'h004B;
  localparam logic [15:0] VEC_DR   = 16'h0053;
  localparam logic [15:0] VEC_AM   = 16'h005B;
  localparam logic [15:0] VEC_WAKE = 16'h0063;

  // Serial peripheral ready is raised after this many bits.
  localparam int SPI_BITS = 8;

endpackage : eiu_pkg

// ### eiu_edge.sv
// Rising edge detector with three-flop input synchroniser.
`timescale 1ns/1ps
`default_nettype none

module eiu_edge #(
  parameter int WIDTH = 5
) (
  input  wire logic             core_clk, // CPU clock
  input  wire logic             arst_n,   // Asynchronous reset
  input  wire logic [WIDTH-1:0] sig_in,   // Asynchronous inputs
  output logic      [WIDTH-1:0] rise_q    // One-cycle rise pulses
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] rise_hold_q;

  initial begin
    if (WIDTH < 1) $error("eiu_edge: WIDTH must be positive.");
  end

  // The first stage only feeds the second so metastability stays contained.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= sig_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A rise counts once stages two and three agree on the new level.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rise_q <= '0;
    end else begin
      rise_q <= s2_q & s3_q & ~rise_hold_q;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rise_hold_q <= '0;
    end else begin
      rise_hold_q <= s2_q & s3_q;
    end
  end

endmodule : eiu_edge
`default_nettype wire

// ### eiu_core.sv
// Extended interrupt unit: flags, enables, priorities, vectoring and nesting.
//
// Contract
// - Rising edge on radio address match sets its flag.
// - Rising edge on radio data ready sets its flag.
// - Serial peripheral finishing eight bits sets its ready flag.
// - Rising edge on converter end-of-conversion sets its flag.
// - Hardware never clears edge flags; software writing one raises interrupt.
// - Reserved bits read as fixed ones and zeros per register.
// - Wakeup event from pin or timer sets the wakeup flag.
// - Wakeup flag left set causes the wakeup interrupt again.
// - Software writing one to wakeup flag raises enabled interrupt.
// - Per-source enable bits four to zero, one enables.
// - Per-source priority bits at enable positions, one is high.
// - Accepted interrupt vectors to that source's fixed address.
// - Routine is pre-empted only by a higher level request.
// - Return resumes at the instruction after the interrupted one.
// - Current instruction finishes before servicing begins.
// - After return or enable/priority write, one more instruction first.
// - Cleared global enable masks everything; set defers to own enables.
// - Vectors 0x43, 0x4B, 0x53, 0x5B, 0x63 by source.
// - Same-level requests granted in natural order, converter first.
`timescale 1ns/1ps
`default_nettype none

module eiu_core #(
  parameter int SPI_BITS = eiu_pkg::SPI_BITS
) (
  input  wire logic        core_clk,       // CPU clock, 200 MHz
  input  wire logic        arst_n,         // Asynchronous reset, low
  input  wire logic        radio_address_match, // Radio address match
  input  wire logic        radio_data_ready,    // Radio data ready
  input  wire logic        adc_eoc,        // Converter end of conversion
  input  wire logic        wakeup_event,   // Pin or timer wakeup level
  input  wire logic        spi_bit_done,   // Serial peripheral bit pulse
  input  wire logic        sfr_wr,         // SFR write strobe
  input  wire logic        sfr_rd,         // SFR read strobe
  input  wire logic [7:0]  sfr_addr,       // SFR address
  input  wire logic [7:0]  sfr_wdata,      // SFR write data
  input  wire logic        instr_end,      // Instruction boundary pulse
  input  wire logic        instr_is_reti,  // Ending instruction is return
  input  wire logic        irq_ack,        // Core took the vector
  output logic [7:0]       sfr_rdata_q,    // SFR read data
  output logic             irq_req_q,      // Request to the core
  output logic [15:0]      irq_vector_q,   // Routine address
  output logic             irq_level_q,    // Level of the request
  output logic [1:0]       active_q        // Levels in service
);

  logic [4:0] flags_q;          // Index by source.
  logic [4:0] en_q;
  logic [4:0] prio_q;
  logic       global_en_q;
  logic [4:0] rise;
  logic [3:0] spi_cnt_q;
  logic       spi_ready_q;
  logic       hold_q;
  logic       wr_flags;
  logic       wr_wake;
  logic       wr_en;
  logic       wr_prio;
  logic       wr_std;
  logic [4:0] pending;
  logic       hi_any;
  logic       lo_any;
  logic [2:0] pick;
  logic       pick_level;
  logic       may_take;

  initial begin
    if (SPI_BITS < 1 || SPI_BITS > 15) begin
      $error("eiu_core: SPI_BITS must lie between 1 and 15.");
    end
  end

  // Lowest set bit wins, giving natural order with the converter first.
  function automatic logic [2:0] first_set(input logic [4:0] v);
    logic [2:0] idx;
    idx = 3'h7;
    for (int i = eiu_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) idx = 3'(i);
    end
    return idx;
  endfunction : first_set

  function automatic logic [15:0] vec_of(input logic [2:0] idx);
    logic [15:0] v;
    unique case (idx)
      3'h0:    v = eiu_pkg::VEC_ADC;
      3'h1:    v = eiu_pkg::VEC_SPI;
      3'h2:    v = eiu_pkg::VEC_DR;
      3'h3:    v = eiu_pkg::VEC_AM;
      default: v = eiu_pkg::VEC_WAKE;
    endcase
    return v;
  endfunction : vec_of

  eiu_edge #(
    .WIDTH (5)
  ) u_edge (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .sig_in   ({wakeup_event, radio_address_match, radio_data_ready,
                1'b0, adc_eoc}),
    .rise_q   (rise)
  );

  assign wr_flags = sfr_wr && (sfr_addr == eiu_pkg::FLAGS_ADDR);
  assign wr_wake  = sfr_wr && (sfr_addr == eiu_pkg::WAKE_ADDR);
  assign wr_en    = sfr_wr && (sfr_addr == eiu_pkg::ENABLE_ADDR);
  assign wr_prio  = sfr_wr && (sfr_addr == eiu_pkg::PRIO_ADDR);
  assign wr_std   = sfr_wr && ((sfr_addr == eiu_pkg::STD_EN_ADDR) ||
                               (sfr_addr == eiu_pkg::STD_PRIO_ADDR));

  // The serial peripheral ready flag follows a full byte of bit pulses.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      spi_cnt_q   <= 4'h0;
      spi_ready_q <= 1'b0;
    end else begin
      spi_ready_q <= 1'b0;
      if (spi_bit_done) begin
        if (spi_cnt_q == 4'(SPI_BITS - 1)) begin
          spi_cnt_q   <= 4'h0;
          spi_ready_q <= 1'b1;
        end else begin
          spi_cnt_q <= spi_cnt_q + 4'h1;
        end
      end
    end
  end

  // Hardware only sets; a write may clear or set, and a set event wins.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= 5'h00;
    end else begin
      if (wr_flags) begin
        flags_q[eiu_pkg::SRC_ADC] <= sfr_wdata[eiu_pkg::FLAG_ADC_BIT];
        flags_q[eiu_pkg::SRC_SPI] <= sfr_wdata[eiu_pkg::FLAG_SPI_BIT];
        flags_q[eiu_pkg::SRC_DR]  <= sfr_wdata[eiu_pkg::FLAG_DR_BIT];
        flags_q[eiu_pkg::SRC_AM]  <= sfr_wdata[eiu_pkg::FLAG_AM_BIT];
      end
      if (wr_wake) begin
        flags_q[eiu_pkg::SRC_WAKE] <= sfr_wdata[eiu_pkg::WAKE_FLAG_BIT];
      end
      if (rise[eiu_pkg::SRC_ADC])  flags_q[eiu_pkg::SRC_ADC] <= 1'b1;
      if (spi_ready_q)             flags_q[eiu_pkg::SRC_SPI] <= 1'b1;
      if (rise[eiu_pkg::SRC_DR])   flags_q[eiu_pkg::SRC_DR]  <= 1'b1;
      if (rise[eiu_pkg::SRC_AM])   flags_q[eiu_pkg::SRC_AM]  <= 1'b1;
      if (rise[eiu_pkg::SRC_WAKE]) flags_q[eiu_pkg::SRC_WAKE] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q        <= eiu_pkg::EN_RESET;
      prio_q      <= eiu_pkg::PRIO_RESET;
      global_en_q <= 1'b0;
    end else begin
      if (wr_en) en_q <= sfr_wdata[4:0];
      if (wr_prio) prio_q <= sfr_wdata[4:0];
      if (sfr_wr && (sfr_addr == eiu_pkg::STD_EN_ADDR)) begin
        global_en_q <= sfr_wdata[eiu_pkg::GLOBAL_EN_BIT];
      end
    end
  end

  // Read data carries fixed reserved bits and the live flags.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        eiu_pkg::FLAGS_ADDR: sfr_rdata_q <= eiu_pkg::FLAGS_FIXED |
          {flags_q[eiu_pkg::SRC_AM], flags_q[eiu_pkg::SRC_DR],
           flags_q[eiu_pkg::SRC_SPI], flags_q[eiu_pkg::SRC_ADC],
           4'h0};
        eiu_pkg::WAKE_ADDR: sfr_rdata_q <= eiu_pkg::WAKE_FIXED |
          {4'h0, flags_q[eiu_pkg::SRC_WAKE], 3'h0};
        eiu_pkg::ENABLE_ADDR: sfr_rdata_q <= eiu_pkg::EN_FIXED |
          {3'h0, en_q};
        eiu_pkg::PRIO_ADDR: sfr_rdata_q <= eiu_pkg::EN_FIXED |
          {3'h0, prio_q};
        default: sfr_rdata_q <= 8'h00;
      endcase
    end
  end

  // A source requests only with its flag, its enable and the global enable.
  // A wakeup flag still set after return simply requests once more.
  assign pending = flags_q & en_q & {5{global_en_q}};
  assign hi_any  = |(pending & prio_q);
  assign lo_any  = |(pending & ~prio_q);
  assign pick = hi_any ? first_set(pending & prio_q)
                       : first_set(pending & ~prio_q);
  assign pick_level = hi_any;

  // Nothing at or below the level in service may pre-empt it.
  assign may_take = hi_any ? !active_q[1]
                           : (lo_any && (active_q == 2'b00));

  // A return blocks only its own boundary, and a control write also blocks
  // the boundary that ends its instruction, so exactly one more follows.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q <= 1'b0;
    end else if (instr_end) begin
      hold_q <= 1'b0;
    end else if (wr_en || wr_prio || wr_std) begin
      hold_q <= 1'b1;
    end
  end

  // Requests are offered only at an instruction boundary.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_req_q    <= 1'b0;
      irq_vector_q <= 16'h0000;
      irq_level_q  <= 1'b0;
    end else if (irq_ack) begin
      irq_req_q <= 1'b0;
    end else if (instr_end) begin
      irq_req_q    <= may_take && !hold_q && !instr_is_reti &&
                      !wr_en && !wr_prio && !wr_std;
      irq_vector_q <= vec_of(pick);
      irq_level_q  <= pick_level;
    end
  end

  // Service levels: ack pushes the level, return pops the highest one.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= 2'b00;
    end else if (irq_ack && irq_req_q) begin
      if (irq_level_q) active_q[1] <= 1'b1;
      else active_q[0] <= 1'b1;
    end else if (instr_end && instr_is_reti) begin
      if (active_q[1]) active_q[1] <= 1'b0;
      else active_q[0] <= 1'b0;
    end
  end

endmodule : eiu_core
`default_nettype wire

// ### eiu_chk.sv
// Concurrent checks on the ports of the extended interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module eiu_chk #(
  parameter int SPI_BITS = eiu_pkg::SPI_BITS
) (
  input wire logic        core_clk,      // CPU clock
  input wire logic        arst_n,        // Reset, low
  input wire logic        sfr_wr,        // Write strobe
  input wire logic        sfr_rd,        // Read strobe
  input wire logic [7:0]  sfr_addr,      // Address
  input wire logic [7:0]  sfr_wdata,     // Write data
  input wire logic        instr_end,     // Boundary
  input wire logic        instr_is_reti, // Return
  input wire logic        irq_ack,       // Vector taken
  input wire logic [7:0]  sfr_rdata_q,   // Read data
  input wire logic        irq_req_q,     // Request
  input wire logic [15:0] irq_vector_q,  // Vector
  input wire logic        irq_level_q,   // Level
  input wire logic [1:0]  active_q       // In service
);
  logic ga_q;
  logic hold_q;
  logic wr_ctl;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) ga_q <= 1'b0;
    else if (sfr_wr && sfr_addr == 8'hA8) ga_q <= sfr_wdata[7];
  end
  assign wr_ctl = sfr_wr && sfr_addr inside {8'hA8, 8'hB8, 8'hE8, 8'hF8};
  // A control write holds back the boundary that ends its instruction.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) hold_q <= 1'b0;
    else if (instr_end) hold_q <= 1'b0;
    else if (wr_ctl) hold_q <= 1'b1;
  end
  sequence s_take;
    irq_req_q && irq_ack;
  endsequence
  property p_flags_fixed;
    sfr_rd && sfr_addr == 8'h91 |=> sfr_rdata_q[3:0] == 4'h8;
  endproperty
  a_flags_fixed: assert property (p_flags_fixed)
    else $error("flag register reserved bits wrong");
  property p_wake_fixed;
    sfr_rd && sfr_addr == 8'hD8 |=> (sfr_rdata_q & 8'h77) == 8'h40;
  endproperty
  a_wake_fixed: assert property (p_wake_fixed)
    else $error("wakeup register reserved bits wrong");
  property p_en_fixed;
    sfr_rd && sfr_addr inside {8'hE8, 8'hF8} |=> sfr_rdata_q[7:5] == 3'h7;
  endproperty
  a_en_fixed: assert property (p_en_fixed)
    else $error("enable or priority reserved bits wrong");
  property p_vec;
    $rose(irq_req_q) |-> $past(ga_q) && irq_vector_q inside
      {16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063};
  endproperty
  a_vec: assert property (p_vec)
    else $error("request without global enable or bad vector");
  property p_boundary;
    $rose(irq_req_q) |-> $past(instr_end);
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("request raised off an instruction boundary");
  property p_ack;
    s_take |=> !irq_req_q;
  endproperty
  a_ack: assert property (p_ack)
    else $error("request stands after being taken");
  property p_nest;
    s_take |=> active_q[$past(irq_level_q)];
  endproperty
  a_nest: assert property (p_nest)
    else $error("taken level not marked in service");
  property p_preempt;
    $rose(irq_req_q) |->
      !$past(active_q[1]) && (irq_level_q || !$past(active_q[0]));
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("routine pre-empted by equal or lower level");
  property p_reti_hold;
    instr_end && (instr_is_reti || hold_q || wr_ctl) |=> !irq_req_q;
  endproperty
  a_reti_hold: assert property (p_reti_hold)
    else $error("request right after a return");
endmodule : eiu_chk
bind eiu_core eiu_chk #(.SPI_BITS(SPI_BITS)) u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .instr_end(instr_end), .instr_is_reti(instr_is_reti),
  .irq_ack(irq_ack), .sfr_rdata_q(sfr_rdata_q), .irq_req_q(irq_req_q),
  .irq_vector_q(irq_vector_q), .irq_level_q(irq_level_q),
  .active_q(active_q));
`default_nettype wire

// ### eiu_cpu_model.sv
// Core model: instruction boundaries, taking of vectors and returns.
`timescale 1ns/1ps
`default_nettype none
module eiu_cpu_model (
  input  wire logic core_clk,      // CPU clock
  input  wire logic arst_n,        // Reset, low
  input  wire logic irq_req_q,     // Request from the unit
  input  wire logic reti_go,       // Bench asks for a return
  output logic      instr_end,     // Boundary pulse
  output logic      instr_is_reti, // Boundary is a return
  output logic      irq_ack        // Vector taken
);
  logic [1:0] cnt_q;
  logic       go_q;
  always_ff @(posedge core_clk) go_q <= reti_go;
  // Every fourth cycle ends an instruction, so a return lands on one.
  always @(negedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 2'h0;
      instr_end <= 1'b0;
      instr_is_reti <= 1'b0;
      irq_ack <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      instr_end <= (cnt_q == 2'h3);
      instr_is_reti <= (cnt_q == 2'h3) && go_q;
      irq_ack <= irq_req_q && !irq_ack;
    end
  end
endmodule : eiu_cpu_model
`default_nettype wire

// ### extended_interrupt_unit_tb.sv
// Self-checking bench for the extended interrupt unit.
`timescale 1ns/1ps
`default_nettype none
module extended_interrupt_unit_tb;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  ev = 4'h0;
  logic        spi = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wd = 8'h00;
  logic        reti_go = 1'b0;
  logic        ie, ir, ack, req, lvl;
  logic [7:0]  rdq;
  logic [15:0] vec;
  logic [1:0]  act;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [15:0] vt [5] = '{16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063};
  always #2.5 core_clk = ~core_clk;
  eiu_core dut (.core_clk(core_clk), .arst_n(arst_n),
    .radio_address_match(ev[3]), .radio_data_ready(ev[2]),
    .adc_eoc(ev[1]), .wakeup_event(ev[0]), .spi_bit_done(spi),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_addr(addr), .sfr_wdata(wd),
    .instr_end(ie), .instr_is_reti(ir), .irq_ack(ack), .sfr_rdata_q(rdq),
    .irq_req_q(req), .irq_vector_q(vec), .irq_level_q(lvl), .active_q(act));
  eiu_cpu_model cpu (.core_clk(core_clk), .arst_n(arst_n), .irq_req_q(req),
    .reti_go(reti_go), .instr_end(ie), .instr_is_reti(ir), .irq_ack(ack));
  task automatic chk(input logic [17:0] s, input logic [17:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1; addr = a; wd = d;
    @(negedge core_clk) wr = 1'b0;
    @(negedge core_clk);
  endtask : wr8
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    rd = 1'b1; addr = a;
    @(negedge core_clk) rd = 1'b0;
    @(negedge core_clk) chk(rdq, e);
  endtask : rd8
  task automatic take(input logic [15:0] v, input logic l);
    int n;
    n = 0;
    while (req !== 1'b1 && n < 200) begin
      @(negedge core_clk) n++;
    end
    chk({req, lvl, vec}, {1'b1, l, v});
    repeat (2) @(negedge core_clk);
  endtask : take
  task automatic ret();
    int n;
    n = 0;
    reti_go = 1'b1;
    do @(posedge core_clk) n++; while (!(ie && ir) && n < 50);
    chk(n < 50, 1'b1);
    @(negedge core_clk) reti_go = 1'b0;
  endtask : ret
  task automatic none(input int c);
    logic s;
    s = 1'b0;
    repeat (c) @(negedge core_clk) s |= req;
    chk(s, 0);
  endtask : none
  function automatic logic [15:0] exp_vec(input logic [4:0] m);
    for (int k = 0; k < 5; k++) if (m[k]) return vt[k];
    return 16'h0000;
  endfunction : exp_vec
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    #300us;
    error_cnt++;
    give_verdict();
  end
  initial begin
    logic [7:0] r;
    void'($urandom(32'h790847B3));
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    rd8(8'h91, 8'h08);
    rd8(8'hD8, 8'h40);
    rd8(8'hF8, 8'hE0);
    rd8(8'h90, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      wr8(8'hE8, r);
      wr8(8'hF8, ~r);
      rd8(8'hE8, 8'hE0 | r);
      rd8(8'hF8, 8'hE0 | ~r);
    end
    ev = 4'hF;
    repeat (8) @(negedge core_clk);
    rd8(8'h91, 8'hD8);
    rd8(8'hD8, 8'h48);
    ev = 4'h0;
    for (int i = 1; i <= 8; i++) begin
      @(negedge core_clk) spi = 1'b1;
      @(negedge core_clk) spi = 1'b0;
      repeat (6) @(negedge core_clk);
      rd8(8'h91, (i == 8) ? 8'hF8 : 8'hD8);
    end
    repeat (20) @(negedge core_clk);
    rd8(8'h91, 8'hF8);
    wr8(8'hE8, 8'h1F);
    wr8(8'hF8, 8'h00);
    none(40);
    wr8(8'hA8, 8'h80);
    for (int i = 0; i < 5; i++) begin
      take(vt[i], 1'b0);
      if (i < 4) wr8(8'h91, 8'hF0 << (i + 1));
      ret();
    end
    take(16'h0063, 1'b0);
    wr8(8'hD8, 8'h00);
    ret();
    none(40);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'h00 : $urandom;
      // Flags are armed while masked, so the request cannot pass unseen.
      wr8(8'hE8, 8'h00);
      wr8(8'h91, 8'hF0);
      wr8(8'hD8, 8'h08);
      wr8(8'hE8, r);
      if (r[4:0] != 5'h00) take(exp_vec(r[4:0]), 1'b0);
      else none(40);
      wr8(8'h91, 8'h00);
      wr8(8'hD8, 8'h00);
      if (r[4:0] != 5'h00) ret();
    end
    wr8(8'hE8, 8'h1F);
    wr8(8'hF8, 8'h08);
    wr8(8'h91, 8'h10);
    take(16'h0043, 1'b0);
    wr8(8'h91, 8'h50);
    none(40);
    wr8(8'h91, 8'hD0);
    take(16'h005B, 1'b1);
    wr8(8'h91, 8'h00);
    ret();
    ret();
    chk(act, 2'h0);
    give_verdict();
  end
endmodule : extended_interrupt_unit_tb
`default_nettype wire
